// ---- bench/clk_gen_props.sv ----
`timescale 1ns/1ps
module clk_gen_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire logic crystal_input_pin,
	input wire logic cpu_clk,
	input wire logic pll_power_on,
	input wire logic osc_amp_bypass,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase ends on its second cycle
	sequence access_end;
		!pready ##1 pready;
	endsequence
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	apb_wait_a: assert property (psel && $rose(penable) |-> access_end)
		else $error("access phase length wrong");
	err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error response malformed");
	fail_source_a: assert property ($rose(irq) |-> pll_power_on)
		else $error("failure without free clock");
	direct_follow_a: assert property (osc_amp_bypass && !pll_power_on &&
		$past(osc_amp_bypass, 2) && !$past(pll_power_on, 2) |->
		cpu_clk == $past(crystal_input_pin, 2)) else $error("cpu clock not the input");
	// Input half periods are at least two cycles here, so no phase is shorter
	no_glitch_a: assert property (!pll_power_on && $changed(cpu_clk) |=> $stable(cpu_clk))
		else $error("short cpu clock phase");
	strap_hold_a: assert property ($past(presetn, 3) |-> $stable(osc_amp_bypass))
		else $error("mode changed outside reset");
	wdg_default_a: assert property ($rose(osc_amp_bypass) |-> pll_power_on)
		else $error("watchdog not on after reset");
endmodule
bind clk_gen clk_gen_props chk (.*);

// ---- bench/tb_clk_gen.sv ----
`timescale 1ns/1ps
`include "clk_gen_regs.vh"
module tb_clk_gen;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [2:0] strap = 3'h7;
	logic [3:0] half = 4'h2;
	logic pready, pslverr, cpu_clk, pll_power_on, osc_amp_bypass, irq, pin, e;
	logic [2:0] pll_modes [5] = '{`MODE_X4, `MODE_X3, `MODE_X8, `MODE_X5, `MODE_X10};
	integer errors = 0, compares = 0, seed = 95233, i, n;
	integer j;
	logic c;
	// Input half periods keeping PLL input, VCO and CPU rates legal per mode
	logic [3:0] pll_half [5] = '{4'hA, 4'h8, 4'hB, 4'h7, 4'hD};
	// Multiplication factor expected for each strap code
	function automatic integer factor_of(input logic [2:0] m);
		case (m)
			`MODE_X4: factor_of = 4;
			`MODE_X3: factor_of = 3;
			`MODE_X8: factor_of = 8;
			`MODE_X5: factor_of = 5;
			default: factor_of = 10;
		endcase
	endfunction
	// Free tick shortened so a failure shows in 32 cycles
	always #5 pclk = ~pclk;
	xtal_source xs (.pclk(pclk), .run(run), .half(half), .pin(pin));
	clk_gen #(.FREE_DIV(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .clock_mode_strap_pins(strap),
		.crystal_input_pin(pin), .cpu_clk(cpu_clk), .pll_power_on(pll_power_on),
		.osc_amp_bypass(osc_amp_bypass), .irq(irq));
	task end_of_test;
		begin
			$display("errors %0d compares %0d", errors, compares);
			if (errors == 0 && compares > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// One transfer; idle edge first so psel is never set twice in a step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		integer k;
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			k = 0;
			@(posedge pclk);
			while (pready !== 1'b1 && k < 20) begin
				@(posedge pclk);
				k = k + 1;
			end
			if (pready !== 1'b1) begin
				errors = errors + 1;
				end_of_test;
			end
			r = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task wait_sig(input logic lvl, input logic sel);
		begin
			n = 0;
			do begin
				@(posedge pclk);
				n = n + 1;
			end while ((sel ? irq : cpu_clk) !== lvl && n < 200);
			if ((sel ? irq : cpu_clk) !== lvl) begin
				errors = errors + 1;
				end_of_test;
			end
		end
	endtask
	task reset_to(input logic [2:0] s);
		begin
			@(posedge pclk);
			presetn <= 1'b0;
			strap <= s;
			run <= 1'b1;
			half <= 4'h2 + {2'b00, 2'($random(seed))};
			repeat (3) @(posedge pclk);
			presetn <= 1'b1;
			repeat (3) @(posedge pclk);
		end
	endtask
	// Main sequence
	initial begin
		reset_to(`MODE_DIRECT);
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		apb(1'b0, `OFS_MODE, 32'h0);
		chk(r, 32'h33);
		chk({31'h0, osc_amp_bypass}, 32'h1);
		apb(1'b1, `OFS_MASK, 32'h1);
		@(pin);
		@(posedge pclk);
		run <= 1'b0;
		repeat (24) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		wait_sig(1'b1, 1'b1);
		chk({31'h0, irq}, 32'h1);
		run <= 1'b1;
		apb(1'b1, `OFS_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `OFS_MASK, 32'h1);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, `OFS_STATUS, 32'h1);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, `OFS_MODE, 32'h0);
		chk(r & 32'h8, 32'h8);
		// Free clock stays in charge with the input back: phase of one tick
		wait_sig(1'b0, 1'b0);
		wait_sig(1'b1, 1'b0);
		wait_sig(1'b0, 1'b0);
		chk(32'(n), 32'h2);
		reset_to(`MODE_DIRECT);
		apb(1'b1, `OFS_SYSCFG, 32'h10);
		apb(1'b0, `OFS_SYSCFG, 32'h0);
		chk(r, 32'h10);
		repeat (2) @(posedge pclk);
		chk({31'h0, pll_power_on}, 32'h0);
		run <= 1'b0;
		repeat (60) @(posedge pclk);
		apb(1'b0, `OFS_MODE, 32'h0);
		chk(r & 32'h8, 32'h0);
		reset_to(`MODE_PRESCALE);
		apb(1'b0, `OFS_MODE, 32'h0);
		chk(r, 32'h31);
		chk({31'h0, osc_amp_bypass}, 32'h0);
		wait_sig(1'b0, 1'b0);
		wait_sig(1'b1, 1'b0);
		wait_sig(1'b0, 1'b0);
		chk(32'(n), 32'(2 * half));
		// Reserved code runs as direct drive without amplifier bypass
		reset_to(`MODE_RESERVED);
		apb(1'b0, `OFS_MODE, 32'h0);
		chk(r, 32'h30);
		chk({31'h0, osc_amp_bypass}, 32'h0);
		// Every multiplying code keeps the watchdog out
		for (i = 0; i < 5; i = i + 1) begin
			reset_to(pll_modes[i]);
			half <= pll_half[i];
			apb(1'b0, `OFS_MODE, 32'h0);
			chk(r, 32'h10 | 32'(pll_modes[i]));
			// Let the averaged window settle, then count CPU edges per input period
			repeat (2000) @(posedge pclk);
			n = 0;
			c = cpu_clk;
			for (j = 0; j < 2 * pll_half[i]; j = j + 1) begin
				@(posedge pclk);
				if (cpu_clk !== c)
					n = n + 1;
				c = cpu_clk;
			end
			chk(32'(n), 32'(2 * factor_of(pll_modes[i])));
			run <= 1'b0;
			repeat (60) @(posedge pclk);
			apb(1'b0, `OFS_MODE, 32'h0);
			chk(r & 32'h8, 32'h0);
		end
		end_of_test;
	end
endmodule

// ---- bench/xtal_source.sv ----
`timescale 1ns/1ps
module xtal_source (
	input wire logic pclk,
	input wire logic run,
	input wire logic [3:0] half,
	output logic pin
);
	logic [3:0] cnt;
	initial begin
		pin = 1'b0;
		cnt = 4'h0;
	end
	// A dead crystal stops at its last level, as a real one does
	always @(posedge pclk) begin
		if (run && cnt >= half - 4'h1) begin
			pin <= ~pin;
			cnt <= 4'h0;
		end else if (run) begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule

// ---- src/clk_gen.v ----
`timescale 1ns/1ps
`include "clk_gen_regs.vh"
// What this block does
// R1: Strap 001 gives CPU clock equal to input clock divided by two.
// R2: Prescaler mode: each CPU clock phase lasts one input period.
// R3: Prescaler or direct with watchdog enabled: PLL free-runs; disabled: PLL off.
// R4: Strap 011 disables PLL, bypasses amplifier, CPU clock follows input pin; here the PLL stays powered while the watchdog is enabled.
// R5: Direct mode phases follow input duty; two phases equal one input period.
// R6: Watchdog enabled after reset; config bit 4 disables it.
// R7: Watchdog counter counts free-running ticks, cleared on each input edge.
// R8: Failure detected when counter overflows after 16 ticks without edge.
// R9: On failure CPU clock switches to free-running clock, interrupt flagged.
// R10: Free-running clock kept until reset, even if input returns.
// R11: Watchdog disabled: CPU clock from input in direct or prescaler, PLL off.
// R12: Watchdog only active in direct or prescaler modes, never PLL modes; here also active for reserved strap 000.
// R13: Other straps multiply: 111 x4, 110 x3, 101 x8, 100 x5, 010 x10.
// R14: PLL resynchronises every Fth input transition, adjusting smoothly.
// R15: PLL built from input divider, VCO multiplier, output divider per mode.
// R16: System keeps PLL input 1-3.5 MHz and VCO 64-128 MHz.
// R17: System keeps PLL-generated CPU frequency within 16-40 MHz.
// R18: Clock mode latched from strap pins while reset is active; here loaded at the first pclk edge after release.
// R19: Every clock source switch happens without shortened pulses.
module clk_gen #(
	parameter FREE_DIV = `FREE_DIV_DEF
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [2:0] clock_mode_strap_pins,
	input wire crystal_input_pin,
	output reg cpu_clk,
	output reg pll_power_on,
	output reg osc_amp_bypass,
	output reg irq
);
	// Multiplication factor from the divider chain
	localparam [7:0] F_X4 = `X4_VCO_MUL / (`X4_IN_DIV * `X4_OUT_DIV);
	localparam [7:0] F_X3 = `X3_VCO_MUL / (`X3_IN_DIV * `X3_OUT_DIV);
	localparam [7:0] F_X8 = `X8_VCO_MUL / (`X8_IN_DIV * `X8_OUT_DIV);
	localparam [7:0] F_X5 = `X5_VCO_MUL / (`X5_IN_DIV * `X5_OUT_DIV);
	localparam [7:0] F_X10 = `X10_VCO_MUL / (`X10_IN_DIV * `X10_OUT_DIV);

	// Clock source selection states
	localparam [1:0] SRC_DIRECT = 2'h0;
	localparam [1:0] SRC_PRESCALE = 2'h1;
	localparam [1:0] SRC_PLL = 2'h2;
	localparam [1:0] SRC_FREE = 2'h3;

	reg init_phase;
	reg [2:0] clock_mode_strap_bits;
	reg [31:0] system_config_register;
	reg fail_status;
	reg fail_mask;
	reg xtal_q;
	reg xtal_d;
	reg [1:0] src;
	reg [7:0] factor;
	reg [7:0] trans_cnt;
	reg [15:0] meas;
	reg [15:0] window;
	reg [15:0] acc;
	reg [15:0] next_acc;
	reg [16:0] avg_sum;
	reg [1:0] next_src;
	reg next_fail_status;
	wire osc_watchdog_disable;
	wire direct_like;
	wire wdg_active;
	wire xtal_edge;
	wire xtal_rise;
	wire free_tick;
	wire wdg_fail;
	wire apb_access;
	wire apb_write;
	wire [15:0] ff_step;

	assign osc_watchdog_disable = system_config_register[`CFG_WDG_DIS_BIT]; // R6
	assign direct_like = (clock_mode_strap_bits == `MODE_DIRECT) ||
		(clock_mode_strap_bits == `MODE_PRESCALE) ||
		(clock_mode_strap_bits == `MODE_RESERVED);
	// Watchdog never runs when the PLL multiplies
	assign wdg_active = direct_like && !osc_watchdog_disable; // R12
	assign xtal_edge = xtal_q ^ xtal_d;
	assign xtal_rise = xtal_q & ~xtal_d;
	assign apb_access = psel && penable && pready;
	assign apb_write = apb_access && pwrite;
	assign ff_step = {8'h00, factor} * {8'h00, factor};

	// Strap capture: held during reset, loaded at the release edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_phase <= 1'b1;
			clock_mode_strap_bits <= `STRAP_RST;
		end else begin
			init_phase <= 1'b0;
			if (init_phase) begin
				clock_mode_strap_bits <= clock_mode_strap_pins; // R18
			end
		end
	end

	// Factor lookup for the multiplying modes
	always @* begin
		case (clock_mode_strap_bits)
			`MODE_X4: factor = F_X4; // R13 R15
			`MODE_X3: factor = F_X3; // R13 R15
			`MODE_X8: factor = F_X8; // R13 R15
			`MODE_X5: factor = F_X5; // R13 R15
			`MODE_X10: factor = F_X10; // R13 R15
			default: factor = 8'h01;
		endcase
	end

	// Input pin sampled once; inputs are synchronous to pclk
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xtal_q <= 1'b0;
			xtal_d <= 1'b0;
		end else begin
			xtal_q <= crystal_input_pin;
			xtal_d <= xtal_q;
		end
	end

	free_run_divider #(
		.DIV(FREE_DIV)
	) u_free (
		.clk(pclk),
		.rst_n(presetn),
		.run(pll_power_on),
		.restart(wdg_fail && src != SRC_FREE),
		.tick(free_tick)
	);

	osc_watchdog u_wdg (
		.clk(pclk),
		.rst_n(presetn),
		.enable(wdg_active),
		.tick(free_tick),
		.xtal_edge(xtal_edge),
		.fail(wdg_fail)
	);

	// Source selection; free-running takeover is one-way until reset
	always @* begin
		next_src = src;
		if (init_phase) begin
			if (clock_mode_strap_pins == `MODE_PRESCALE) begin
				next_src = SRC_PRESCALE; // R1
			end else if (clock_mode_strap_pins == `MODE_DIRECT ||
				clock_mode_strap_pins == `MODE_RESERVED) begin
				next_src = SRC_DIRECT; // R4
			end else begin
				next_src = SRC_PLL; // R13
			end
		end else if (wdg_fail) begin
			next_src = SRC_FREE; // R9 R10
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src <= SRC_PLL;
		end else begin
			src <= next_src;
		end
	end

	// PLL power and amplifier bypass; PLL off when watchdog is disabled in direct or prescaler mode
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_power_on <= 1'b0;
			osc_amp_bypass <= 1'b0;
		end else begin
			if (src == SRC_PLL) begin
				pll_power_on <= 1'b1;
			end else if (src == SRC_FREE) begin
				pll_power_on <= 1'b1; // R9
			end else begin
				pll_power_on <= !osc_watchdog_disable; // R3 R11
			end
			osc_amp_bypass <= (clock_mode_strap_bits == `MODE_DIRECT); // R4
		end
	end

	// Window measurement: pclk cycles across F input transitions
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trans_cnt <= 8'h00;
			meas <= 16'h0000;
			window <= 16'h0000;
		end else if (src != SRC_PLL) begin
			trans_cnt <= 8'h00;
			meas <= 16'h0000;
			window <= 16'h0000;
		end else if (xtal_edge && trans_cnt == factor - 8'h01) begin
			trans_cnt <= 8'h00;
			meas <= 16'h0001;
			// Average old and new window; rounding toward the new one lets it settle exactly
			if (window == 16'h0000) begin
				window <= meas; // R14
			end else begin
				window <= avg_sum[16:1] + {15'h0000, meas > window}; // R14
			end
		end else begin
			if (xtal_edge) begin
				trans_cnt <= trans_cnt + 8'h01;
			end
			if (meas != 16'hFFFF) begin
				meas <= meas + 16'h0001;
			end
		end
	end

	always @* begin
		avg_sum = {1'b0, window} + {1'b0, meas};
	end

	// Phase accumulator: F*F toggles per window of F transitions
	always @* begin
		next_acc = acc + ff_step;
		if (window != 16'h0000 && next_acc >= window) begin
			next_acc = next_acc - window;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= 16'h0000;
		end else if (src != SRC_PLL || window == 16'h0000) begin
			acc <= 16'h0000;
		end else begin
			acc <= next_acc; // R14
		end
	end

	// CPU clock per source; a takeover holds the level for a full tick
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_clk <= 1'b0;
		end else begin
			case (src)
				SRC_DIRECT: begin
					if (!wdg_fail) begin
						cpu_clk <= xtal_q; // R5 R11
					end
				end
				SRC_PRESCALE: begin
					if (xtal_rise && !wdg_fail) begin
						cpu_clk <= ~cpu_clk; // R1 R2
					end
				end
				SRC_PLL: begin
					if (window != 16'h0000 && acc + ff_step >= window) begin
						cpu_clk <= ~cpu_clk; // R13
					end
				end
				SRC_FREE: begin
					if (free_tick) begin
						cpu_clk <= ~cpu_clk; // R9 R19
					end
				end
				default: cpu_clk <= 1'b0;
			endcase
		end
	end

	// Failure flag: set beats a same-cycle write-one clear
	always @* begin
		next_fail_status = fail_status;
		if (apb_write && paddr == `OFS_STATUS && pwdata[`STS_FAIL_BIT]) begin
			next_fail_status = 1'b0;
		end
		if (wdg_fail && src != SRC_FREE) begin
			next_fail_status = 1'b1; // R9
		end
	end

	// Register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_config_register <= `SYSCFG_RST; // R6
			fail_status <= 1'b0;
			fail_mask <= 1'b0;
		end else begin
			fail_status <= next_fail_status;
			if (apb_write && paddr == `OFS_SYSCFG) begin
				system_config_register <= pwdata; // R6
			end
			if (apb_write && paddr == `OFS_MASK) begin
				fail_mask <= pwdata[`STS_FAIL_BIT];
			end
		end
	end

	// Level interrupt while unmasked status is set
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= fail_status && fail_mask;
		end
	end

	// APB slave: one wait state, registered answer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			case (paddr)
				`OFS_SYSCFG: begin
					if (!pwrite) begin
						prdata <= system_config_register;
					end
				end
				`OFS_STATUS: begin
					if (!pwrite) begin
						prdata <= {31'h0000_0000, fail_status};
					end
				end
				`OFS_MASK: begin
					if (!pwrite) begin
						prdata <= {31'h0000_0000, fail_mask};
					end
				end
				`OFS_MODE: begin
					if (!pwrite) begin
						prdata <= {26'h000_0000, wdg_active, pll_power_on,
							src == SRC_FREE, clock_mode_strap_bits};
					end
				end
				default: pslverr <= 1'b1;
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule

// ---- src/clk_gen_regs.vh ----
`ifndef CLK_GEN_REGS_VH
`define CLK_GEN_REGS_VH

// Register byte offsets
`define OFS_SYSCFG 12'h000
`define OFS_STATUS 12'h004
`define OFS_MASK 12'h008
`define OFS_MODE 12'h00C

// Field positions
`define CFG_WDG_DIS_BIT 4
`define STS_FAIL_BIT 0
`define MODE_FAIL_BIT 3
`define MODE_PLL_BIT 4
`define MODE_WDG_BIT 5

// Reset values
`define SYSCFG_RST 32'h0000_0000
`define STRAP_RST 3'h7

// Strap codes
`define MODE_X4 3'h7
`define MODE_X3 3'h6
`define MODE_X8 3'h5
`define MODE_X5 3'h4
`define MODE_DIRECT 3'h3
`define MODE_X10 3'h2
`define MODE_PRESCALE 3'h1
`define MODE_RESERVED 3'h0

// PLL input divider, VCO multiplier, output divider per mode
`define X4_IN_DIV 4
`define X4_VCO_MUL 64
`define X4_OUT_DIV 4
`define X3_IN_DIV 4
`define X3_VCO_MUL 48
`define X3_OUT_DIV 4
`define X8_IN_DIV 4
`define X8_VCO_MUL 64
`define X8_OUT_DIV 2
`define X5_IN_DIV 4
`define X5_VCO_MUL 40
`define X5_OUT_DIV 2
`define X10_IN_DIV 2
`define X10_VCO_MUL 40
`define X10_OUT_DIV 2

// Watchdog overflow after this many free-running ticks
`define WDG_OVF_TICKS 16
// Default pclk cycles per free-running tick
`define FREE_DIV_DEF 8

`endif

// ---- src/free_run_divider.v ----
`timescale 1ns/1ps
// Free-running oscillator stand-in: one-cycle tick every DIV pclk cycles
module free_run_divider #(
	parameter DIV = 8
) (
	input wire clk,
	input wire rst_n,
	input wire run,
	input wire restart,
	output reg tick
);
	reg [15:0] cnt;

	// Restart lets a clock takeover begin with a full phase
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 16'h0000;
			tick <= 1'b0;
		end else if (!run || restart) begin
			cnt <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt == DIV[15:0] - 16'h0001) begin
			cnt <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 16'h0001;
			tick <= 1'b0;
		end
	end
endmodule

// ---- src/osc_watchdog.v ----
`timescale 1ns/1ps
`include "clk_gen_regs.vh"
// Counts free-running ticks, cleared by each input edge; sticky failure
module osc_watchdog (
	input wire clk,
	input wire rst_n,
	input wire enable,
	input wire tick,
	input wire xtal_edge,
	output reg fail
);
	reg [4:0] cnt;

	// Input edge wins over a tick in the same cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 5'h00;
			fail <= 1'b0;
		end else begin
			if (!enable || xtal_edge) begin
				cnt <= 5'h00; // R7
			end else if (tick && !fail) begin
				cnt <= cnt + 5'h01; // R7
			end
			// Only reset clears the failure
			if (enable && !xtal_edge && tick && cnt == `WDG_OVF_TICKS - 1) begin
				fail <= 1'b1; // R8 R10
			end
		end
	end
endmodule
